// ==== verilog/crs_consts.vh ====
// Constants for the reset and initialisation sequencer
`ifndef CRS_CONSTS_VH
`define CRS_CONSTS_VH
`define CRS_START_FETCH_ADDR 32'hFFFF_FFF0
`define CRS_MCW_COLD 32'h0600_0010
`define CRS_MCW_CD_BIT 30
`define CRS_MCW_NW_BIT 29
`define CRS_MCW_ET_BIT 4
`define CRS_CS_SEL 16'hF000
`define CRS_CS_BASE 32'hFFFF_0000
`define CRS_CS_LIMIT 32'h0000_FFFF
`define CRS_IP_RESET 32'h0000_FFF0
`define CRS_FPU_CW_INIT 16'h037F
`define CRS_FPU_SW_INIT 16'h0000
`define CRS_FPU_TW_INIT 16'hFFFF
`define CRS_ADDR_HOLD_IN_PRE 3'h2
`define CRS_ADDR_HOLD_IN_POST 3'h2
`define CRS_BUILTIN_SELF_TEST_CYCLES 32'h0008_0000
`endif

// ==== verilog/crs_sequencer.v ====
// Reset type decode and architectural state initialisation sequencer
//
// Operation
// RULE1 - Cold reset high means cold reset, init high alone means warm reset, both low means none.
// RULE2 - After any reset the fetch address is the fixed start address near the top of memory.
// RULE3 - Cold reset invalidates both caches without writing back modified lines.
// RULE4 - Warm reset leaves the cache contents and valid state unchanged.
// RULE5 - Plain cold reset and warm reset do not initialise the floating-point state.
// RULE6 - Every reset invalidates branch buffer, descriptor cache and both translation buffers.
// RULE7 - Self test is requested by holding address hold high two clocks before and after cold reset falls.
// RULE8 - Cold reset with self test initialises the floating-point control, status, tag and pointers.
// RULE9 - At the end of every reset the identification register holds component and stepping codes.
// RULE10 - Cold reset loads the machine control word; warm reset keeps cache bits, sets bit 4, clears others.
// RULE11 - Every reset loads code segment selector, base, limit and the instruction pointer.
// RULE12 - Cold reset clears time stamp, event select and cache test register; warm reset keeps them.
// RULE13 - After reset the bus control pins take their defined levels and the data lines float.
// RULE14 - Self test ends by writing the result to the accumulator, zero meaning pass.
// RULE15 - No bus cycle is started while self test runs.
// RULE16 - The reset, init and address hold pins are synchronised before decoding.
`timescale 1ns/10ps
`include "crs_consts.vh"
module crs_sequencer #(
  parameter [31:0] BUILTIN_SELF_TEST_CYCLES = `CRS_BUILTIN_SELF_TEST_CYCLES,
  parameter [7:0] COMPONENT_ID = 8'hA5, // Arbitrary value
  parameter [7:0] STEPPING_ID = 8'h01 // Arbitrary value
)
(
  // Clock and reset
  input wire core_clk_i,
  input wire sys_rst_i,
  // Pins from system logic
  input wire cold_reset_pin_i,
  input wire warm_init_pin_i,
  input wire addr_hold_in_i,
  // Self test engine result
  input wire [31:0] builtin_self_test_result_i,
  // Fetch and architectural state
  output reg [31:0] fetch_addr_o,
  output reg fetch_go_o,
  output reg [15:0] ident_result_reg_o,
  output reg [31:0] accumulator_reg_o,
  output reg [31:0] machine_control_word_o,
  output reg [15:0] cs_selector_o,
  output reg [31:0] cs_base_o,
  output reg [31:0] cs_limit_o,
  output reg [31:0] instruction_pointer_o,
  output reg [63:0] time_stamp_o,
  output reg [31:0] event_select_o,
  output reg [31:0] cache_ctl_test_reg_o,
  // Floating-point state
  output reg [15:0] fpu_control_word_o,
  output reg [15:0] fpu_status_word_o,
  output reg [15:0] fpu_tag_word_o,
  output reg [31:0] fpu_pointers_o,
  output reg fpu_state_valid_o,
  // Invalidation pulses
  output reg icache_inval_o,
  output reg dcache_inval_o,
  output reg branch_target_buffer_inval_o,
  output reg segment_descriptor_cache_inval_o,
  output reg itlb_inval_o,
  output reg dtlb_inval_o,
  output reg dcache_writeback_o,
  // Self test status
  output reg builtin_self_test_busy_o,
  output reg [1:0] reset_type_o,
  // Bus pins
  output reg lock_n_o,
  output reg addr_strobe_n_o,
  output reg parity_check_n_o,
  output reg snoop_hit_n_o,
  output reg snoop_hit_modified_n_o,
  output reg float_error_n_o,
  output reg mgmt_mode_active_n_o,
  output reg hold_acknowledge_o,
  output reg bus_request_o,
  output reg [31:0] data_out_o,
  output reg data_oe_o
);

  localparam [3:0] ST_RUN = 4'h1;
  localparam [3:0] ST_HOLD = 4'h2;
  localparam [3:0] ST_BUILTIN_SELF_TEST = 4'h4;
  localparam [3:0] ST_LOAD = 4'h8;

  localparam [1:0] RT_NONE = 2'h0;
  localparam [1:0] RT_WARM = 2'h1;
  localparam [1:0] RT_COLD = 2'h2;
  localparam [1:0] RT_BUILTIN_SELF_TEST = 2'h3;

  // Pin synchronisers
  reg [1:0] cold_sync_r;
  reg [1:0] init_sync_r;
  reg [1:0] addr_hold_in_sync_r;
  wire cold_s = cold_sync_r[1];
  wire init_s = init_sync_r[1];
  wire addr_hold_in_s = addr_hold_in_sync_r[1];

  always @(posedge core_clk_i)
  begin
    if (sys_rst_i)
    begin
      cold_sync_r <= 2'h0;
      init_sync_r <= 2'h0;
      addr_hold_in_sync_r <= 2'h0;
    end
    else
    begin
      cold_sync_r <= {cold_sync_r[0], cold_reset_pin_i}; // RULE16
      init_sync_r <= {init_sync_r[0], warm_init_pin_i}; // RULE16
      addr_hold_in_sync_r <= {addr_hold_in_sync_r[0], addr_hold_in_i}; // RULE16
    end
  end

  reg [3:0] state_r;
  reg [3:0] state_nxt;
  reg [2:0] addr_hold_in_pre_r;
  reg [2:0] addr_hold_in_post_r;
  reg builtin_self_test_req_r;
  reg [31:0] builtin_self_test_cnt_r;
  reg init_prev_r;
  // Init is edge triggered, so a held init gives one warm reset
  wire init_rise = init_s & ~init_prev_r & ~cold_s;
  wire builtin_self_test_cand = addr_hold_in_pre_r >= `CRS_ADDR_HOLD_IN_PRE;

  // Next state
  always @*
  begin
    state_nxt = state_r;
    case (state_r)
      ST_RUN:
        if (cold_s)
          state_nxt = ST_HOLD;
      ST_HOLD:
        if (!cold_s)
          state_nxt = builtin_self_test_cand ? ST_BUILTIN_SELF_TEST : ST_LOAD; // RULE1
      ST_BUILTIN_SELF_TEST:
        if (cold_s)
          state_nxt = ST_HOLD;
        else if (addr_hold_in_post_r >= `CRS_ADDR_HOLD_IN_POST && !builtin_self_test_req_r)
          state_nxt = ST_LOAD; // RULE7
        else if (builtin_self_test_cnt_r >= BUILTIN_SELF_TEST_CYCLES)
          state_nxt = ST_LOAD;
      ST_LOAD:
        state_nxt = cold_s ? ST_HOLD : ST_RUN;
      default:
        state_nxt = ST_HOLD;
    endcase
  end

  // Sequencer state
  always @(posedge core_clk_i)
  begin
    if (sys_rst_i)
    begin
      state_r <= ST_HOLD;
      init_prev_r <= 1'b0;
    end
    else
    begin
      state_r <= state_nxt;
      init_prev_r <= init_s;
    end
  end

  // Address hold count while cold reset is high; a gap restarts it
  always @(posedge core_clk_i)
  begin
    if (sys_rst_i)
      addr_hold_in_pre_r <= 3'h0;
    else if (!cold_s || !addr_hold_in_s)
      addr_hold_in_pre_r <= 3'h0;
    else if (addr_hold_in_pre_r != 3'h7)
      addr_hold_in_pre_r <= addr_hold_in_pre_r + 3'h1; // RULE7
  end

  // Self test is only confirmed two clocks after the fall, so it may still abort
  // Cleared in hold so a request never outlives its own cold reset
  always @(posedge core_clk_i)
  begin
    if (sys_rst_i)
    begin
      builtin_self_test_req_r <= 1'b0;
      addr_hold_in_post_r <= 3'h0;
    end
    else if (state_r == ST_HOLD)
    begin
      builtin_self_test_req_r <= !cold_s && builtin_self_test_cand && addr_hold_in_s; // RULE7
      addr_hold_in_post_r <= (!cold_s && builtin_self_test_cand) ? 3'h1 : 3'h0;
    end
    else if (state_r == ST_BUILTIN_SELF_TEST && addr_hold_in_post_r < `CRS_ADDR_HOLD_IN_POST)
    begin
      addr_hold_in_post_r <= addr_hold_in_post_r + 3'h1;
      if (!addr_hold_in_s)
        builtin_self_test_req_r <= 1'b0; // RULE7
    end
  end

  // Self test duration
  always @(posedge core_clk_i)
  begin
    if (sys_rst_i)
      builtin_self_test_cnt_r <= 32'h0000_0000;
    else if (state_r == ST_BUILTIN_SELF_TEST)
      builtin_self_test_cnt_r <= builtin_self_test_cnt_r + 32'h0000_0001;
    else
      builtin_self_test_cnt_r <= 32'h0000_0000;
  end

  wire do_cold = (state_r == ST_LOAD);
  wire do_warm = (state_r == ST_RUN) && init_rise; // RULE1
  // A self test reset needs the request still standing after the window
  wire with_builtin_self_test = do_cold && builtin_self_test_req_r && (addr_hold_in_post_r >= `CRS_ADDR_HOLD_IN_POST);
  wire any_reset = do_cold | do_warm;
  wire [31:0] mcw_warm = (machine_control_word_o &
    ((32'h0000_0001 << `CRS_MCW_CD_BIT) | (32'h0000_0001 << `CRS_MCW_NW_BIT)))
    | (32'h0000_0001 << `CRS_MCW_ET_BIT);

  // Architectural state loading
  always @(posedge core_clk_i)
  begin
    if (sys_rst_i)
    begin
      fetch_addr_o <= `CRS_START_FETCH_ADDR;
      fetch_go_o <= 1'b0;
      ident_result_reg_o <= 16'h0000;
      accumulator_reg_o <= 32'h0000_0000;
      machine_control_word_o <= `CRS_MCW_COLD;
      cs_selector_o <= `CRS_CS_SEL;
      cs_base_o <= `CRS_CS_BASE;
      cs_limit_o <= `CRS_CS_LIMIT;
      instruction_pointer_o <= `CRS_IP_RESET;
      event_select_o <= 32'h0000_0000;
      cache_ctl_test_reg_o <= 32'h0000_0000;
      fpu_control_word_o <= 16'h0000;
      fpu_status_word_o <= 16'h0000;
      fpu_tag_word_o <= 16'h0000;
      fpu_pointers_o <= 32'h0000_0000;
      fpu_state_valid_o <= 1'b0;
      icache_inval_o <= 1'b0;
      dcache_inval_o <= 1'b0;
      branch_target_buffer_inval_o <= 1'b0;
      segment_descriptor_cache_inval_o <= 1'b0;
      itlb_inval_o <= 1'b0;
      dtlb_inval_o <= 1'b0;
      dcache_writeback_o <= 1'b0;
      reset_type_o <= RT_NONE;
    end
    else
    begin
      fetch_go_o <= any_reset;
      icache_inval_o <= do_cold; // RULE3 RULE4
      dcache_inval_o <= do_cold; // RULE3 RULE4
      dcache_writeback_o <= 1'b0; // RULE3
      branch_target_buffer_inval_o <= any_reset; // RULE6
      segment_descriptor_cache_inval_o <= any_reset; // RULE6
      itlb_inval_o <= any_reset; // RULE6
      dtlb_inval_o <= any_reset; // RULE6
      if (any_reset)
      begin
        fetch_addr_o <= `CRS_START_FETCH_ADDR; // RULE2
        ident_result_reg_o <= {COMPONENT_ID, STEPPING_ID}; // RULE9
        cs_selector_o <= `CRS_CS_SEL; // RULE11
        cs_base_o <= `CRS_CS_BASE; // RULE11
        cs_limit_o <= `CRS_CS_LIMIT; // RULE11
        instruction_pointer_o <= `CRS_IP_RESET; // RULE11
      end
      if (do_warm)
      begin
        reset_type_o <= RT_WARM;
        accumulator_reg_o <= 32'h0000_0000;
        machine_control_word_o <= mcw_warm; // RULE10
      end
      if (do_cold)
      begin
        reset_type_o <= with_builtin_self_test ? RT_BUILTIN_SELF_TEST : RT_COLD;
        machine_control_word_o <= `CRS_MCW_COLD; // RULE10
        event_select_o <= 32'h0000_0000; // RULE12
        cache_ctl_test_reg_o <= 32'h0000_0000; // RULE12
        accumulator_reg_o <= with_builtin_self_test ? builtin_self_test_result_i : 32'h0000_0000; // RULE14
        if (with_builtin_self_test)
        begin
          fpu_control_word_o <= `CRS_FPU_CW_INIT; // RULE8
          fpu_status_word_o <= `CRS_FPU_SW_INIT; // RULE8
          fpu_tag_word_o <= `CRS_FPU_TW_INIT; // RULE8
          fpu_pointers_o <= 32'h0000_0000; // RULE8
          fpu_state_valid_o <= 1'b1;
        end
        else
          fpu_state_valid_o <= 1'b0; // RULE5
      end
    end
  end

  // Time stamp runs outside reset and self test, so a warm reset visibly keeps it
  always @(posedge core_clk_i)
  begin
    if (sys_rst_i)
      time_stamp_o <= 64'h0000_0000_0000_0000;
    else if (do_cold)
      time_stamp_o <= 64'h0000_0000_0000_0000; // RULE12
    else if (state_nxt != ST_BUILTIN_SELF_TEST && state_r != ST_BUILTIN_SELF_TEST && !cold_s)
      time_stamp_o <= time_stamp_o + 64'h0000_0000_0000_0001; // RULE12
  end

  // Bus pin levels
  // Pins stay at their reset levels; no bus engine lives in this block
  always @(posedge core_clk_i)
  begin
    if (sys_rst_i)
    begin
      builtin_self_test_busy_o <= 1'b0;
      lock_n_o <= 1'b1;
      addr_strobe_n_o <= 1'b1;
      parity_check_n_o <= 1'b1;
      snoop_hit_n_o <= 1'b1;
      snoop_hit_modified_n_o <= 1'b1;
      float_error_n_o <= 1'b1;
      mgmt_mode_active_n_o <= 1'b1;
      hold_acknowledge_o <= 1'b0;
      bus_request_o <= 1'b0;
      data_out_o <= 32'h0000_0000;
      data_oe_o <= 1'b0;
    end
    else
    begin
      builtin_self_test_busy_o <= (state_nxt == ST_BUILTIN_SELF_TEST); // RULE15
      if (state_nxt != ST_RUN || any_reset)
      begin
        lock_n_o <= 1'b1; // RULE13
        addr_strobe_n_o <= 1'b1; // RULE13 RULE15
        parity_check_n_o <= 1'b1; // RULE13
        snoop_hit_n_o <= 1'b1; // RULE13
        snoop_hit_modified_n_o <= 1'b1; // RULE13
        float_error_n_o <= 1'b1; // RULE13
        mgmt_mode_active_n_o <= 1'b1; // RULE13
        hold_acknowledge_o <= 1'b0; // RULE13
        bus_request_o <= 1'b0; // RULE13 RULE15
        data_oe_o <= 1'b0; // RULE13
      end
    end
  end

endmodule

// ==== verification/crs_sequencer_assertions.sv ====
// Port assertions for the reset sequencer
`timescale 1ns/10ps
`include "crs_consts.vh"
module crs_seq_chk #(
  parameter [15:0] IDENT = 16'hA501 // Arbitrary value
)
(
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic sys_rst_i,
  // Architectural state
  input wire logic [31:0] fetch_addr_o,
  input wire logic [31:0] machine_control_word_o,
  input wire logic [31:0] instruction_pointer_o,
  input wire logic [31:0] cs_base_o,
  input wire logic [31:0] cs_limit_o,
  input wire logic [31:0] event_select_o,
  input wire logic [31:0] cache_ctl_test_reg_o,
  input wire logic [15:0] ident_result_reg_o,
  input wire logic [15:0] cs_selector_o,
  input wire logic [1:0] reset_type_o,
  input wire logic fetch_go_o,
  // Floating-point state
  input wire logic [15:0] fpu_control_word_o,
  input wire logic [15:0] fpu_status_word_o,
  input wire logic [15:0] fpu_tag_word_o,
  input wire logic [31:0] fpu_pointers_o,
  input wire logic fpu_state_valid_o,
  // Invalidation pulses and self test
  input wire logic icache_inval_o,
  input wire logic dcache_inval_o,
  input wire logic dcache_writeback_o,
  input wire logic branch_target_buffer_inval_o,
  input wire logic segment_descriptor_cache_inval_o,
  input wire logic itlb_inval_o,
  input wire logic dtlb_inval_o,
  input wire logic builtin_self_test_busy_o,
  // Bus pins
  input wire logic lock_n_o,
  input wire logic addr_strobe_n_o,
  input wire logic parity_check_n_o,
  input wire logic snoop_hit_n_o,
  input wire logic snoop_hit_modified_n_o,
  input wire logic float_error_n_o,
  input wire logic mgmt_mode_active_n_o,
  input wire logic hold_acknowledge_o,
  input wire logic bus_request_o,
  input wire logic data_oe_o
);
  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (sys_rst_i);
  property p_cold_inval;
    icache_inval_o |-> dcache_inval_o && reset_type_o[1] && !dcache_writeback_o;
  endproperty
  a_cold_inval: assert property (p_cold_inval) else $error("cold invalidate wrong");
  property p_any_inval;
    branch_target_buffer_inval_o |-> itlb_inval_o && dtlb_inval_o && segment_descriptor_cache_inval_o;
  endproperty
  a_any_inval: assert property (p_any_inval) else $error("buffer invalidate wrong");
  property p_arch;
    branch_target_buffer_inval_o |-> cs_selector_o == `CRS_CS_SEL && instruction_pointer_o == `CRS_IP_RESET
      && ident_result_reg_o == IDENT && cs_base_o == `CRS_CS_BASE && cs_limit_o == `CRS_CS_LIMIT;
  endproperty
  a_arch: assert property (p_arch) else $error("start state wrong");
  property p_fetch;
    fetch_go_o |-> fetch_addr_o == `CRS_START_FETCH_ADDR;
  endproperty
  a_fetch: assert property (p_fetch) else $error("fetch address wrong");
  property p_mcw_cold;
    icache_inval_o |-> machine_control_word_o == `CRS_MCW_COLD;
  endproperty
  a_mcw_cold: assert property (p_mcw_cold) else $error("cold control word wrong");
  property p_cold_clear;
    icache_inval_o |-> event_select_o == 32'h0000_0000 && cache_ctl_test_reg_o == 32'h0000_0000;
  endproperty
  a_cold_clear: assert property (p_cold_clear) else $error("cold test registers not cleared");
  property p_warm;
    branch_target_buffer_inval_o && !icache_inval_o |-> reset_type_o == 2'h1 && $stable(fpu_control_word_o)
      && machine_control_word_o == (($past(machine_control_word_o) & 32'h6000_0000) | 32'h0000_0010)
      && $stable(fpu_state_valid_o) && $stable(event_select_o);
  endproperty
  a_warm: assert property (p_warm) else $error("warm state wrong");
  property p_fpu;
    branch_target_buffer_inval_o && reset_type_o == 2'h3 |-> fpu_control_word_o == `CRS_FPU_CW_INIT
      && fpu_state_valid_o && fpu_status_word_o == `CRS_FPU_SW_INIT && fpu_tag_word_o == `CRS_FPU_TW_INIT
      && fpu_pointers_o == 32'h0000_0000;
  endproperty
  a_fpu: assert property (p_fpu) else $error("self test fpu init wrong");
  property p_quiet;
    builtin_self_test_busy_o |-> addr_strobe_n_o && !bus_request_o;
  endproperty
  a_quiet: assert property (p_quiet) else $error("bus cycle during self test");
  property p_pins;
    branch_target_buffer_inval_o |=> (lock_n_o && addr_strobe_n_o && parity_check_n_o && snoop_hit_n_o
      && snoop_hit_modified_n_o && float_error_n_o && mgmt_mode_active_n_o && !hold_acknowledge_o
      && !bus_request_o && !data_oe_o) [*3];
  endproperty
  a_pins: assert property (p_pins) else $error("pin levels wrong");
endmodule
bind crs_sequencer crs_seq_chk #(.IDENT({COMPONENT_ID, STEPPING_ID})) chk_u
(
  .core_clk_i, .sys_rst_i, .fetch_addr_o, .machine_control_word_o, .instruction_pointer_o, .cs_base_o,
  .cs_limit_o, .event_select_o, .cache_ctl_test_reg_o, .ident_result_reg_o, .cs_selector_o, .reset_type_o,
  .fetch_go_o, .fpu_control_word_o, .fpu_status_word_o, .fpu_tag_word_o, .fpu_pointers_o, .fpu_state_valid_o,
  .icache_inval_o, .dcache_inval_o, .dcache_writeback_o, .branch_target_buffer_inval_o,
  .segment_descriptor_cache_inval_o, .itlb_inval_o, .dtlb_inval_o, .builtin_self_test_busy_o,
  .lock_n_o, .addr_strobe_n_o, .parity_check_n_o, .snoop_hit_n_o, .snoop_hit_modified_n_o, .float_error_n_o,
  .mgmt_mode_active_n_o, .hold_acknowledge_o, .bus_request_o, .data_oe_o
);

// ==== verification/crs_sys_model.sv ====
// System reset logic model driving the reset pins
`timescale 1ns/10ps
module crs_sys_model
(
  // Clock
  input wire core_clk_i,
  // Pins to the device
  output reg cold_reset_pin_o = 1'b0,
  output reg warm_init_pin_o = 1'b0,
  output reg addr_hold_in_o = 1'b0
);
  // Kind 1 warm, 2 cold, 3 cold with self test, 4 cold with init high
  task run(input [2:0] kind, input integer wid, input integer post);
  begin
    @(posedge core_clk_i);
    if (kind == 3'h1)
    begin
      warm_init_pin_o <= 1'b1;
      repeat (wid) @(posedge core_clk_i);
      warm_init_pin_o <= 1'b0;
    end
    else
    begin
      addr_hold_in_o <= (kind == 3'h3);
      repeat (3) @(posedge core_clk_i);
      cold_reset_pin_o <= 1'b1;
      warm_init_pin_o <= (kind == 3'h4);
      repeat (wid) @(posedge core_clk_i);
      cold_reset_pin_o <= 1'b0;
      warm_init_pin_o <= 1'b0;
      repeat (post) @(posedge core_clk_i);
      addr_hold_in_o <= 1'b0;
    end
  end
  endtask
endmodule

// ==== verification/crs_sequencer_tb_top.sv ====
// Self-checking bench for the reset sequencer
`timescale 1ns/10ps
`include "crs_consts.vh"
`define CK(n, e, s) begin check_count++; if ((s) !== (e)) begin mismatches++; \
  $display("MISMATCH %s exp %h got %h", n, e, s); end end
module crs_sequencer_tb_top;
  reg core_clk_i = 1'b0;
  reg sys_rst_i = 1'b1;
  reg [31:0] builtin_self_test_result_i = 32'h0000_0000;
  wire cold_w, warm_w, addr_hold_in_w;
  wire [31:0] accumulator_reg_o, machine_control_word_o;
  wire [63:0] time_stamp_o;
  wire [15:0] fpu_control_word_o;
  wire [1:0] reset_type_o;
  wire fpu_state_valid_o, icache_inval_o, branch_target_buffer_inval_o, builtin_self_test_busy_o;
  integer seed = 96201;
  integer mismatches = 0;
  integer check_count = 0;
  integer i, n, bcnt, post;
  reg hit, ic, pval;
  reg [2:0] kind;
  reg [1:0] t;
  reg [31:0] pmcw;
  reg [63:0] pts;
  reg [15:0] pcw;
  crs_sequencer #(.BUILTIN_SELF_TEST_CYCLES(32'h0000_0010)) dut_u
  (
    .core_clk_i, .sys_rst_i, .cold_reset_pin_i(cold_w), .warm_init_pin_i(warm_w), .addr_hold_in_i(addr_hold_in_w),
    .builtin_self_test_result_i, .fetch_addr_o(), .fetch_go_o(), .ident_result_reg_o(), .accumulator_reg_o,
    .machine_control_word_o, .cs_selector_o(), .cs_base_o(), .cs_limit_o(), .instruction_pointer_o(),
    .time_stamp_o, .event_select_o(), .cache_ctl_test_reg_o(), .fpu_control_word_o, .fpu_status_word_o(),
    .fpu_tag_word_o(), .fpu_pointers_o(), .fpu_state_valid_o, .icache_inval_o, .dcache_inval_o(),
    .branch_target_buffer_inval_o, .segment_descriptor_cache_inval_o(), .itlb_inval_o(), .dtlb_inval_o(),
    .dcache_writeback_o(), .builtin_self_test_busy_o, .reset_type_o, .lock_n_o(), .addr_strobe_n_o(),
    .parity_check_n_o(), .snoop_hit_n_o(), .snoop_hit_modified_n_o(), .float_error_n_o(),
    .mgmt_mode_active_n_o(), .hold_acknowledge_o(), .bus_request_o(), .data_out_o(), .data_oe_o()
  );
  crs_sys_model sys_u (.core_clk_i, .cold_reset_pin_o(cold_w), .warm_init_pin_o(warm_w), .addr_hold_in_o(addr_hold_in_w));
  function [1:0] exp_type(input [2:0] k, input integer p);
    exp_type = (k == 3'h1) ? 2'h1 : (k == 3'h3 && p >= 2) ? 2'h3 : 2'h2;
  endfunction
  task wait_reset;
  begin
    hit = 1'b0;
    bcnt = 0;
    for (n = 0; n < 200 && hit !== 1'b1; n++)
    begin
      @(posedge core_clk_i);
      #1;
      bcnt += builtin_self_test_busy_o;
      hit = branch_target_buffer_inval_o;
    end
    ic = icache_inval_o;
  end
  endtask
  task test_done;
  begin
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  end
  endtask
  initial
  begin
    forever #4 core_clk_i = ~core_clk_i;
  end
  initial
  begin
    repeat (5000) @(posedge core_clk_i);
    mismatches++;
    test_done;
  end
  initial
  begin
    repeat (20) @(posedge core_clk_i);
    sys_rst_i <= 1'b0;
    wait_reset;
    for (i = 0; i < 16; i++)
    begin
      kind = (i < 4) ? i + 1 : (i == 5) ? 3'h3 : 3'h1 + $unsigned($random(seed)) % 4;
      post = (i == 5) ? 0 : 2;
      t = exp_type(kind, post);
      pmcw = machine_control_word_o;
      pts = time_stamp_o;
      pcw = fpu_control_word_o;
      pval = fpu_state_valid_o;
      @(posedge core_clk_i);
      builtin_self_test_result_i <= (i == 2) ? 32'h0000_0000 : $random(seed);
      fork
        sys_u.run(kind, 2 + $unsigned($random(seed)) % 4, post);
        wait_reset;
      join
      `CK("icache", t[1], ic)
      `CK("type", t, reset_type_o)
      @(posedge core_clk_i);
      #1;
      `CK("mcw", (t == 2'h1) ? (pmcw & 32'h6000_0000) | 32'h0000_0010 : `CRS_MCW_COLD, machine_control_word_o)
      `CK("acc", (t == 2'h3) ? builtin_self_test_result_i : 32'h0000_0000, accumulator_reg_o)
      `CK("busy", t == 2'h3, bcnt >= 16)
      `CK("tsc", 1'b1, (t == 2'h1) ? time_stamp_o > pts : time_stamp_o < 64'h4)
      `CK("fval", (t == 2'h3) ? 1'b1 : (t == 2'h2) ? 1'b0 : pval, fpu_state_valid_o)
      if (t != 2'h2)
        `CK("fcw", (t == 2'h3) ? `CRS_FPU_CW_INIT : pcw, fpu_control_word_o)
    end
    test_done;
  end
endmodule
